// >>> pkg/ptc_pkg.sv
// constants shared by the phy test and configuration register group
// assumes a single 25 mhz core clock and 16-bit management data
`default_nettype none
package ptc_pkg;
  // register offsets in the management address space
  localparam logic [15:0] OFS_LOW_VOLTAGE_10M = 16'hb403;
  localparam logic [15:0] OFS_TENMEG_TEST     = 16'hb412;
  localparam logic [15:0] OFS_FAST_TX_TEST    = 16'hb413;
  localparam logic [15:0] OFS_RX_TERM         = 16'hb685;
  localparam logic [15:0] OFS_CABLE_DIAG      = 16'hba1b;

  // field positions and widths
  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned SEL_W      = 3;

  // reset values of the stored fields
  localparam logic       RST_LOW_VOLTAGE_10M = 1'h1;
  localparam logic [2:0] RST_TENMEG_TEST     = 3'h0;
  localparam logic [2:0] RST_FAST_TX_TEST    = 3'h0;
  localparam logic       RST_RX_TERM         = 1'h1;
  localparam logic       RST_CABLE_DIAG      = 1'h0;

  // 10 mbps square-wave selector codes
  localparam logic [2:0] TEN_OFF      = 3'h0;
  localparam logic [2:0] TEN_10M_DIM0 = 3'h1;
  localparam logic [2:0] TEN_10M_DIM1 = 3'h2;
  localparam logic [2:0] TEN_5M_DIM0  = 3'h3;
  localparam logic [2:0] TEN_5M_DIM1  = 3'h4;

  // 100 mbps mlt3 selector codes
  localparam logic [2:0] FAST_OFF        = 3'h0;
  localparam logic [2:0] FAST_SHORT_ALT  = 3'h2;
  localparam logic [2:0] FAST_SHORT_DIM0 = 3'h3;
  localparam logic [2:0] FAST_LONG_DIM1  = 3'h4;

  // mlt3 level encoding on the driver port
  localparam logic [1:0] MLT3_ZERO = 2'h0;
  localparam logic [1:0] MLT3_POS  = 2'h1;
  localparam logic [1:0] MLT3_NEG  = 2'h3;

  // timing: times in ns, counts in core clock cycles
  localparam int unsigned CLK_NS        = 40;
  localparam int unsigned HALF_10M_NS   = 50;
  localparam int unsigned HALF_5M_NS    = 100;
  localparam int unsigned DWELL_SHORT_NS = 16;
  localparam int unsigned DWELL_LONG_NS  = 112;
  // all times round down, never below one cycle
  localparam int unsigned HALF_10M_CYC =
    (HALF_10M_NS / CLK_NS < 1) ? 1 : HALF_10M_NS / CLK_NS;
  localparam int unsigned HALF_5M_CYC =
    (HALF_5M_NS / CLK_NS < 1) ? 1 : HALF_5M_NS / CLK_NS;
  localparam int unsigned DWELL_SHORT_CYC =
    (DWELL_SHORT_NS / CLK_NS < 1) ? 1 : DWELL_SHORT_NS / CLK_NS;
  localparam int unsigned DWELL_LONG_CYC =
    (DWELL_LONG_NS / CLK_NS < 1) ? 1 : DWELL_LONG_NS / CLK_NS;
  localparam int unsigned CNT_W = 4;
endpackage
`default_nettype wire

// >>> src/ptc_mlt3_wave.sv
// 100 mbps mlt3 test waveform generator
// assumes the selector is a registered field of the register group
`default_nettype none
module ptc_mlt3_wave (
  input  wire logic       clk_sys_i,  // core clock
  input  wire logic       rst_n_i,    // async reset, active low
  input  wire logic [2:0] sel_i,      // test selector code
  output logic            dim0_en_o,  // waveform on dimension 0
  output logic            dim1_en_o,  // waveform on dimension 1
  output logic [1:0]      level_o     // mlt3 level code
);
  typedef enum logic [1:0] {
    ST_ZERO_A, ST_POS, ST_ZERO_B, ST_NEG
  } ptc_mlt3_t;
  ptc_mlt3_t  st_q;
  logic [3:0] dwell;
  logic [3:0] cnt_q;
  logic       step;
  logic       active;

  // decode; 010 mirrors 011, everything unlisted is off
  always_comb begin
    dim0_en_o = 1'b0;
    dim1_en_o = 1'b0;
    dwell     = 4'(ptc_pkg::DWELL_SHORT_CYC);
    case (sel_i)
      ptc_pkg::FAST_SHORT_DIM0,
      ptc_pkg::FAST_SHORT_ALT: dim0_en_o = 1'b1;
      ptc_pkg::FAST_LONG_DIM1: begin
        dim1_en_o = 1'b1;
        dwell     = 4'(ptc_pkg::DWELL_LONG_CYC);
      end
      default: ;
    endcase
  end
  // end of dwell; >= so a long-to-short switch mid-count steps at once
  assign active = dim0_en_o | dim1_en_o;
  assign step   = active && (cnt_q >= dwell - 4'h1);

  // dwell counter; 16 ns is below one clock so it clamps to one
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
    end else if (!active || step) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // level sequence zero, positive, zero, negative, repeating
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= ST_ZERO_A;
    end else if (!active) begin
      st_q <= ST_ZERO_A;
    end else if (step) begin
      case (st_q)
        ST_ZERO_A: st_q <= ST_POS;
        ST_POS:    st_q <= ST_ZERO_B;
        ST_ZERO_B: st_q <= ST_NEG;
        ST_NEG:    st_q <= ST_ZERO_A;
        default:   st_q <= ST_ZERO_A;
      endcase
    end
  end

  // level code; zero from the first clock edge after going idle
  always_comb begin
    case (st_q)
      ST_POS:  level_o = ptc_pkg::MLT3_POS;
      ST_NEG:  level_o = ptc_pkg::MLT3_NEG;
      default: level_o = ptc_pkg::MLT3_ZERO;
    endcase
  end
endmodule
`default_nettype wire

// >>> src/ptc_regs.sv
// phy test and configuration register group with its pattern sources
// assumes a decoded management port: one access per cycle, 16-bit data
//
// How it works
// - bit 0 of the low-voltage register enables 10BASE-Te, resets to one
// - three-bit 10 mbps selector gives the 5 and 10 mhz square waves as 6.25 and 12.5 mhz
// - selector code 000 means no test signal; reset value is 000
// - codes 001 and 010 give 10 mhz on dimension 0 and 1
// - codes 011 and 100 give 5 mhz on dimension 0 and 1
// - 100 mbps test steps zero, positive, zero, negative, repeating
// - each mlt3 level dwells short (16 ns, clamped to one 40 ns clock) or long (112 ns, rounded down to 80 ns)
// - 100 mbps selector code 000 disables the waveform; reset value
// - 100 mbps code 100 gives long dwell on dimension 1
// - 100 mbps codes 011 and 010 give short dwell on dimension 0
// - termination bit resets to one; zero selects lowest common-mode Z
// - writing one to the diagnostic start bit launches a cable run
// - start bit clears itself when the run finishes
`default_nettype none
module ptc_regs (
  input  wire logic        clk_sys_i,        // core clock, 25 mhz
  input  wire logic        rst_n_i,          // async reset, active low
  input  wire logic [15:0] mgmt_addr_i,      // register address
  input  wire logic        mgmt_wr_i,        // write strobe
  input  wire logic [15:0] mgmt_wdata_i,     // write data
  input  wire logic        mgmt_rd_i,        // read strobe
  output logic      [15:0] mgmt_rdata_o,     // read data, next cycle
  output logic             mgmt_rvalid_o,    // read data valid pulse
  output logic             low_voltage_10m_o, // 10BASE-Te enable level
  output logic             rx_termination_low_power_o, // term select
  output logic             ten_dim0_en_o,    // 10m pattern on dim 0
  output logic             ten_dim1_en_o,    // 10m pattern on dim 1
  output logic             ten_level_o,      // 10m square-wave level
  output logic             fast_dim0_en_o,   // mlt3 pattern on dim 0
  output logic             fast_dim1_en_o,   // mlt3 pattern on dim 1
  output logic       [1:0] fast_level_o,     // mlt3 level code
  output logic             cable_diag_go_o,  // start pulse to engine
  input  wire logic        cable_diag_done_i // engine finished pulse
);
  logic       low_voltage_10m_q;
  logic [2:0] tenmeg_test_signal_select_q;
  logic [2:0] fast_tx_test_waveform_select_q;
  logic       rx_termination_low_power_q;
  logic       cable_diag_start_q;
  logic [15:0] rdata_d;
  logic       wr_lv;
  logic       wr_ten;
  logic       wr_fast;
  logic       wr_term;
  logic       wr_diag;
  logic       diag_launch;

  // write decode, one strobe per register
  assign wr_lv   = mgmt_wr_i && (mgmt_addr_i == ptc_pkg::OFS_LOW_VOLTAGE_10M);
  assign wr_ten  = mgmt_wr_i && (mgmt_addr_i == ptc_pkg::OFS_TENMEG_TEST);
  assign wr_fast = mgmt_wr_i && (mgmt_addr_i == ptc_pkg::OFS_FAST_TX_TEST);
  assign wr_term = mgmt_wr_i && (mgmt_addr_i == ptc_pkg::OFS_RX_TERM);
  assign wr_diag = mgmt_wr_i && (mgmt_addr_i == ptc_pkg::OFS_CABLE_DIAG);

  // launch only from idle, so a rewrite during a run is not a new run
  assign diag_launch = wr_diag && mgmt_wdata_i[ptc_pkg::BIT_ENABLE]
                       && !cable_diag_start_q;

  // 10BASE-Te enable, only bit 0 is stored
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_voltage_10m_q <= ptc_pkg::RST_LOW_VOLTAGE_10M;
    end else if (wr_lv) begin
      low_voltage_10m_q <= mgmt_wdata_i[ptc_pkg::BIT_ENABLE];
    end
  end

  // 10 mbps test selector
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tenmeg_test_signal_select_q <= ptc_pkg::RST_TENMEG_TEST;
    end else if (wr_ten) begin
      tenmeg_test_signal_select_q <= mgmt_wdata_i[2:0];
    end
  end

  // 100 mbps test selector
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fast_tx_test_waveform_select_q <= ptc_pkg::RST_FAST_TX_TEST;
    end else if (wr_fast) begin
      fast_tx_test_waveform_select_q <= mgmt_wdata_i[2:0];
    end
  end

  // receive termination select
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_termination_low_power_q <= ptc_pkg::RST_RX_TERM;
    end else if (wr_term) begin
      rx_termination_low_power_q <= mgmt_wdata_i[ptc_pkg::BIT_ENABLE];
    end
  end

  // diagnostic start: a launch in the done cycle wins over the clear;
  // writing zero never aborts a run, the engine owns the end of it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cable_diag_start_q <= ptc_pkg::RST_CABLE_DIAG;
    end else if (diag_launch) begin
      cable_diag_start_q <= 1'b1;
    end else if (cable_diag_done_i) begin
      cable_diag_start_q <= 1'b0;
    end
  end

  // one-cycle go pulse to the measurement engine; standby is software's
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cable_diag_go_o <= 1'b0;
    end else begin
      cable_diag_go_o <= diag_launch;
    end
  end

  // read mux; upper bits and unmapped addresses read zero
  always_comb begin
    rdata_d = 16'h0000;
    case (mgmt_addr_i)
      ptc_pkg::OFS_LOW_VOLTAGE_10M: rdata_d[0] = low_voltage_10m_q;
      ptc_pkg::OFS_TENMEG_TEST:  rdata_d[2:0] = tenmeg_test_signal_select_q;
      ptc_pkg::OFS_FAST_TX_TEST: rdata_d[2:0] = fast_tx_test_waveform_select_q;
      ptc_pkg::OFS_RX_TERM:      rdata_d[0] = rx_termination_low_power_q;
      ptc_pkg::OFS_CABLE_DIAG:   rdata_d[0] = cable_diag_start_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mgmt_rdata_o  <= 16'h0000;
      mgmt_rvalid_o <= 1'b0;
    end else begin
      mgmt_rvalid_o <= mgmt_rd_i;
      if (mgmt_rd_i) begin
        mgmt_rdata_o <= rdata_d;
      end
    end
  end

  assign low_voltage_10m_o          = low_voltage_10m_q;
  assign rx_termination_low_power_o = rx_termination_low_power_q;

  // 10 mbps square-wave source
  ptc_square_wave u_square (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .sel_i     (tenmeg_test_signal_select_q),
    .dim0_en_o (ten_dim0_en_o),
    .dim1_en_o (ten_dim1_en_o),
    .level_o   (ten_level_o)
  );

  // 100 mbps mlt3 waveform source
  ptc_mlt3_wave u_mlt3 (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .sel_i     (fast_tx_test_waveform_select_q),
    .dim0_en_o (fast_dim0_en_o),
    .dim1_en_o (fast_dim1_en_o),
    .level_o   (fast_level_o)
  );
endmodule
`default_nettype wire

// >>> src/ptc_square_wave.sv
// 10 mbps square-wave test pattern generator
// assumes the selector is a registered field of the register group
`default_nettype none
module ptc_square_wave (
  input  wire logic       clk_sys_i,  // core clock
  input  wire logic       rst_n_i,    // async reset, active low
  input  wire logic [2:0] sel_i,      // test selector code
  output logic            dim0_en_o,  // pattern drives dimension 0
  output logic            dim1_en_o,  // pattern drives dimension 1
  output logic            level_o     // square-wave level
);
  logic [3:0] half_cyc;
  logic [3:0] cnt_q;
  logic       tick;
  logic       active;

  // decode; reserved and disabled codes leave both dimensions idle
  always_comb begin
    dim0_en_o = 1'b0;
    dim1_en_o = 1'b0;
    half_cyc  = 4'(ptc_pkg::HALF_10M_CYC);
    case (sel_i)
      ptc_pkg::TEN_10M_DIM0: dim0_en_o = 1'b1;
      ptc_pkg::TEN_10M_DIM1: dim1_en_o = 1'b1;
      ptc_pkg::TEN_5M_DIM0: begin
        dim0_en_o = 1'b1;
        half_cyc  = 4'(ptc_pkg::HALF_5M_CYC);
      end
      ptc_pkg::TEN_5M_DIM1: begin
        dim1_en_o = 1'b1;
        half_cyc  = 4'(ptc_pkg::HALF_5M_CYC);
      end
      default: ;
    endcase
  end
  // end of half period; >= so a shorter period picked mid-count never
  // lets the counter run on and wrap before the next toggle
  assign active = dim0_en_o | dim1_en_o;
  assign tick   = active && (cnt_q >= half_cyc - 4'h1);

  // half-period divider; 10 mhz is coarse at this clock rate
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
    end else if (!active || tick) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // level toggles on each half-period enable, rests low when idle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= 1'b0;
    end else if (!active) begin
      level_o <= 1'b0;
    end else if (tick) begin
      level_o <= ~level_o;
    end
  end
endmodule
`default_nettype wire

// >>> verif/ptc_regs_bench.sv
// self-checking bench for the phy test register group
// assumes the package, design and checker are compiled first
`default_nettype none
module ptc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, wr, rd_s, done, rv, lv, rxt, go;
  logic        t0, t1, tl, f0, f1;
  logic [1:0]  fl;
  logic [15:0] addr, wdata, rdata, a, d;
  int          mismatches, tests_run, seed, n;
  logic [15:0] adr [5] = '{ptc_pkg::OFS_LOW_VOLTAGE_10M,
    ptc_pkg::OFS_TENMEG_TEST, ptc_pkg::OFS_FAST_TX_TEST,
    ptc_pkg::OFS_RX_TERM, 16'hb404};

  ptc_regs i_ptc_regs (.clk_sys_i(clk), .rst_n_i(rst_n),
    .mgmt_addr_i(addr), .mgmt_wr_i(wr), .mgmt_wdata_i(wdata),
    .mgmt_rd_i(rd_s), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rv),
    .low_voltage_10m_o(lv), .rx_termination_low_power_o(rxt),
    .ten_dim0_en_o(t0), .ten_dim1_en_o(t1), .ten_level_o(tl),
    .fast_dim0_en_o(f0), .fast_dim1_en_o(f1), .fast_level_o(fl),
    .cable_diag_go_o(go), .cable_diag_done_i(done));

  // 25 mhz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask

  // strobes rise 2 ns after an edge and drop after the taking edge
  task automatic wr_reg(logic [15:0] ad, logic [15:0] dat);
    @(posedge clk);
    #2;
    addr = ad;
    wdata = dat;
    wr = 1'b1;
    @(posedge clk);
    #2;
    wr = 1'b0;
  endtask

  task automatic rd_reg(logic [15:0] ad, logic [15:0] e);
    @(posedge clk);
    #2;
    addr = ad;
    rd_s = 1'b1;
    @(posedge clk);
    #2;
    rd_s = 1'b0;
    chk("rvalid", 16'h1, {15'h0, rv});
    chk("rdata", e, rdata);
  endtask

  // readback: one-bit and three-bit fields, everything else zero
  function automatic logic [15:0] exp_rd(logic [15:0] ad, logic [15:0] v);
    if (ad == adr[0] || ad == adr[3]) begin
      return {15'h0, v[0]};
    end
    if (ad == adr[1] || ad == adr[2]) begin
      return {13'h0, v[2:0]};
    end
    return 16'h0;
  endfunction

  // select a code, let it settle, then count level changes over 8 cycles
  task automatic pat(bit fast, logic [2:0] c);
    logic [1:0] prev;
    logic [1:0] en;
    int         tg;
    int         et;
    en = fast ? {c == 3'h4, c == 3'h2 || c == 3'h3}
              : {c == 3'h2 || c == 3'h4, c == 3'h1 || c == 3'h3};
    et = fast ? ((c == 3'h2 || c == 3'h3) ? 8 : (c == 3'h4) ? 4 : 0)
              : ((c == 3'h1 || c == 3'h2) ? 8 : (en != 2'h0) ? 4 : 0);
    wr_reg(adr[fast ? 2 : 1], {13'h0, c});
    repeat (6) @(posedge clk);
    #2;
    tg = 0;
    prev = fast ? fl : {1'b0, tl};
    repeat (8) begin
      @(posedge clk);
      #2;
      if ((fast ? fl : {1'b0, tl}) !== prev) tg++;
      prev = fast ? fl : {1'b0, tl};
    end
    chk("enables", {14'h0, en}, {14'h0, fast ? {f1, f0} : {t1, t0}});
    chk("changes", et[15:0], tg[15:0]);
    if (et == 0) chk("idle level", 16'h0, {14'h0, prev});
  endtask

  task automatic results;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    seed = $urandom(92);
    {rst_n, wr, rd_s, done} = 4'h0;
    addr = 16'h0;
    wdata = 16'h0;
    repeat (8) @(posedge clk);
    #2;
    rst_n = 1'b1;
    chk("te out", 16'h1, {15'h0, lv});
    chk("term out", 16'h1, {15'h0, rxt});
    // reset values: enable bits one, both selectors zero
    for (n = 0; n < 4; n++) begin
      d = (n == 0 || n == 3) ? 16'h1 : 16'h0;
      rd_reg(adr[n], exp_rd(adr[n], d));
    end
    rd_reg(ptc_pkg::OFS_CABLE_DIAG, 16'h0);
    // random writes, including an unmapped address and reserved codes
    for (n = 0; n < 24; n++) begin
      a = adr[$urandom_range(0, 4)];
      d = (n < 2) ? 16'hfffe : $urandom();
      wr_reg(a, d);
      rd_reg(a, exp_rd(a, d));
      if (a == adr[0]) chk("te out", {15'h0, d[0]}, {15'h0, lv});
      if (a == adr[3]) chk("term out", {15'h0, d[0]}, {15'h0, rxt});
    end
    for (n = 0; n < 16; n++) pat(n[3], n[2:0]);
    // diagnostic start: pulse once, ignore zero and repeated ones
    // no phy core here, so standby before the start is taken as given
    wr_reg(ptc_pkg::OFS_CABLE_DIAG, 16'h0001);
    chk("go", 16'h1, {15'h0, go});
    rd_reg(ptc_pkg::OFS_CABLE_DIAG, 16'h0001);
    wr_reg(ptc_pkg::OFS_CABLE_DIAG, 16'h0000);
    wr_reg(ptc_pkg::OFS_CABLE_DIAG, 16'hffff);
    chk("go again", 16'h0, {15'h0, go});
    rd_reg(ptc_pkg::OFS_CABLE_DIAG, 16'h0001);
    repeat ($urandom_range(1, 20)) @(posedge clk);
    #2;
    done = 1'b1;
    @(posedge clk);
    #2;
    done = 1'b0;
    rd_reg(ptc_pkg::OFS_CABLE_DIAG, 16'h0000);
    results();
  end
endmodule
`default_nettype wire

// >>> verif/ptc_regs_properties.sv
// port-level assertions for the phy test register group
// assumes a bind onto ptc_regs, one clock, async active-low reset
`default_nettype none
module ptc_regs_checker (
  input wire logic        clk_sys_i,     // core clock
  input wire logic        rst_n_i,       // reset, active low
  input wire logic [15:0] mgmt_addr_i,   // address
  input wire logic        mgmt_wr_i,     // write strobe
  input wire logic [15:0] mgmt_wdata_i,  // write data
  input wire logic        mgmt_rd_i,     // read strobe
  input wire logic [15:0] mgmt_rdata_o,  // read data
  input wire logic        mgmt_rvalid_o, // read valid
  input wire logic        low_voltage_10m_o, // te enable
  input wire logic        rx_termination_low_power_o, // term
  input wire logic        ten_dim0_en_o, // 10m dim 0
  input wire logic        ten_dim1_en_o, // 10m dim 1
  input wire logic        ten_level_o,   // 10m level
  input wire logic        fast_dim0_en_o, // mlt3 dim 0
  input wire logic        fast_dim1_en_o, // mlt3 dim 1
  input wire logic [1:0]  fast_level_o,  // mlt3 level
  input wire logic        cable_diag_go_o, // start pulse
  input wire logic        cable_diag_done_i // run finished
);
  logic [2:0] ten_sel_q;
  logic [2:0] fast_sel_q;
  logic       start_q;
  wire logic wr_cd = mgmt_wr_i && mgmt_addr_i == ptc_pkg::OFS_CABLE_DIAG;
  wire logic launch = wr_cd && mgmt_wdata_i[0] && !start_q;
  wire logic ten10 = ten_sel_q == 3'h1 || ten_sel_q == 3'h2;
  wire logic ten5 = ten_sel_q == 3'h3 || ten_sel_q == 3'h4;
  wire logic fshort = fast_sel_q == 3'h2 || fast_sel_q == 3'h3;
  wire logic flong = fast_sel_q == 3'h4;

  // shadow selectors, tracked from writes only, never from outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ten_sel_q <= 3'h0;
    end else if (mgmt_wr_i && mgmt_addr_i == ptc_pkg::OFS_TENMEG_TEST) begin
      ten_sel_q <= mgmt_wdata_i[2:0];
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fast_sel_q <= 3'h0;
    end else if (mgmt_wr_i && mgmt_addr_i == ptc_pkg::OFS_FAST_TX_TEST) begin
      fast_sel_q <= mgmt_wdata_i[2:0];
    end
  end
  // start shadow: set wins over done
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q <= 1'b0;
    end else if (launch) begin
      start_q <= 1'b1;
    end else if (cable_diag_done_i) begin
      start_q <= 1'b0;
    end
  end

  // mirror of an mlt3 level half a cycle of the pattern later
  function automatic logic [1:0] mir(input logic [1:0] l);
    return (l == ptc_pkg::MLT3_ZERO) ? ptc_pkg::MLT3_ZERO :
           (l == ptc_pkg::MLT3_POS) ? ptc_pkg::MLT3_NEG : ptc_pkg::MLT3_POS;
  endfunction

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  AST_LV_WRITE: assert property (
    mgmt_wr_i && mgmt_addr_i == ptc_pkg::OFS_LOW_VOLTAGE_10M |=>
    low_voltage_10m_o == $past(mgmt_wdata_i[0]))
    else $error("te enable does not follow write");
  AST_RXT_WRITE: assert property (
    mgmt_wr_i && mgmt_addr_i == ptc_pkg::OFS_RX_TERM |=>
    rx_termination_low_power_o == $past(mgmt_wdata_i[0]))
    else $error("termination does not follow write");
  AST_TEN_DIMS: assert property (
    ten_dim0_en_o == (ten_sel_q == 3'h1 || ten_sel_q == 3'h3) &&
    ten_dim1_en_o == (ten_sel_q == 3'h2 || ten_sel_q == 3'h4))
    else $error("10m dimension enables wrong");
  AST_TEN_IDLE: assert property (
    (!ten10 && !ten5) [*2] |-> !ten_level_o)
    else $error("10m level active while off");
  AST_TEN_10M: assert property (
    ten10 [*3] |-> ten_level_o != $past(ten_level_o))
    else $error("10m wave not toggling each cycle");
  AST_TEN_5M: assert property (
    ten5 [*5] |-> ten_level_o != $past(ten_level_o, 2))
    else $error("5m wave half period wrong");
  AST_FAST_DIMS: assert property (
    fast_dim0_en_o == fshort && fast_dim1_en_o == flong)
    else $error("mlt3 dimension enables wrong");
  AST_FAST_SHORT: assert property (
    fshort [*4] |-> fast_level_o != $past(fast_level_o) &&
    fast_level_o == mir($past(fast_level_o, 2)))
    else $error("short dwell sequence wrong");
  AST_FAST_LONG: assert property (
    flong [*8] |-> fast_level_o != $past(fast_level_o, 2) &&
    fast_level_o == mir($past(fast_level_o, 4)))
    else $error("long dwell sequence wrong");
  AST_FAST_IDLE: assert property (
    (!fshort && !flong) [*2] |-> fast_level_o == ptc_pkg::MLT3_ZERO)
    else $error("mlt3 level active while off");
  AST_GO: assert property (
    cable_diag_go_o == $past(launch))
    else $error("start pulse does not match launch");
  AST_DIAG_READ: assert property (
    mgmt_rvalid_o && $past(mgmt_addr_i) == ptc_pkg::OFS_CABLE_DIAG |->
    mgmt_rdata_o[0] == $past(start_q))
    else $error("start bit readback wrong");
  AST_RSVD: assert property (
    mgmt_rvalid_o |-> mgmt_rdata_o[15:3] == 13'h0)
    else $error("reserved read bits not zero");

  // main scenarios reached
  cover property (fshort [*4]);
  cover property (flong [*8]);
  cover property (cable_diag_go_o);
endmodule

bind ptc_regs ptc_regs_checker i_ptc_regs_checker (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mgmt_addr_i(mgmt_addr_i),
  .mgmt_wr_i(mgmt_wr_i), .mgmt_wdata_i(mgmt_wdata_i),
  .mgmt_rd_i(mgmt_rd_i), .mgmt_rdata_o(mgmt_rdata_o),
  .mgmt_rvalid_o(mgmt_rvalid_o), .low_voltage_10m_o(low_voltage_10m_o),
  .rx_termination_low_power_o(rx_termination_low_power_o),
  .ten_dim0_en_o(ten_dim0_en_o), .ten_dim1_en_o(ten_dim1_en_o),
  .ten_level_o(ten_level_o), .fast_dim0_en_o(fast_dim0_en_o),
  .fast_dim1_en_o(fast_dim1_en_o), .fast_level_o(fast_level_o),
  .cable_diag_go_o(cable_diag_go_o),
  .cable_diag_done_i(cable_diag_done_i));
`default_nettype wire
